/* mmag_map.vh */
`ifndef MMAG_MAP_VH
`define MMAG_MAP_VH
// register byte offsets
`define MMAG_OFS_MODE      8'h00
`define MMAG_OFS_CTRL      8'h04
`define MMAG_OFS_SEG_IDX   8'h08
`define MMAG_OFS_SEG_RT    8'h0c
`define MMAG_OFS_SEG_ST    8'h10
`define MMAG_OFS_SEG_EN    8'h14
`define MMAG_OFS_SEG_OF    8'h18
`define MMAG_OFS_GRP_LO    8'h1c
`define MMAG_OFS_GRP_HI    8'h20
`define MMAG_OFS_BANKED    8'h24
`define MMAG_OFS_STATUS    8'h28
// field positions
`define MMAG_POS_SM        0
`define MMAG_POS_SSM       1
`define MMAG_POS_IRQ_SYS   0
`define MMAG_POS_RT_R      0
`define MMAG_POS_RT_W      1
`define MMAG_POS_RT_X      2
`define MMAG_POS_SEG_GRP   16
// reset values and codes
`define MMAG_RST_CTRL      1'b1
`define MMAG_RST_GRP       8'hff
`define MMAG_RT_END        4'h8
`define MMAG_RT_LINK       4'h9
`define MMAG_FIXED_RDATA   8'h00
`define MMAG_ENTRY_VADDR   24'h800000
// physical memory bases
`define MMAG_RAM_BASE      24'h000000
`define MMAG_EE_BASE       24'h100000
`define MMAG_ROM_BASE      24'h200000
// exception causes
`define MMAG_CAUSE_RANGE   3'h1
`define MMAG_CAUSE_USER    3'h2
`define MMAG_CAUSE_SYSTEM_ENTRY_VECTOR    3'h3
`define MMAG_CAUSE_INTERRUPT_RETURN_INSTRUCTION    3'h4
`endif

/* mmag_guard.v */
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mmag_map.vh"
module mmag_guard #(
	parameter SEG_N    = 64,
	parameter IW       = 6,
	parameter STK_D    = 8,
	parameter SPW      = 4,
	parameter RAM_SIZE = 24'h002000,
	parameter EE_SIZE  = 24'h010000,
	parameter ROM_SIZE = 24'h040000
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// avalon-mm slave
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// straps, sampled while in boot
	input  wire        strap_contactless,
	input  wire        strap_test_avail,
	input  wire        strap_contact_only,
	// cpu memory request
	input  wire        cpu_req,
	input  wire [1:0]  cpu_kind,
	input  wire [23:0] cpu_vaddr,
	// cpu mode events, one-cycle pulses; irq_active is a level
	input  wire        ev_exception,
	input  wire        ev_irq_entry,
	input  wire        ev_interrupt_return_instruction,
	input  wire        ev_system_entry_vector_call,
	input  wire        ev_config_entry_vector_call,
	input  wire        ev_far_call,
	input  wire [23:0] call_target,
	input  wire        irq_active,
	// memory interface
	output reg         mem_req_r,
	output reg  [23:0] mem_addr_r,
	output reg         exc_req_r,
	output reg  [2:0]  exc_cause_r,
	// mode and group rights
	output wire [1:0]  privilege_mode_word,
	output reg  [15:0] grp_rights_r,
	// peripheral register filter
	input  wire        sfr_req,
	input  wire        sfr_wr,
	input  wire        sfr_is_grp,
	input  wire [3:0]  sfr_grp,
	input  wire [1:0]  sfr_cls,
	input  wire [7:0]  sfr_periph_rdata,
	output wire        sfr_wr_en,
	output wire [1:0]  sfr_bank,
	output reg  [7:0]  sfr_rdata_r
);

	// mode states
	localparam ST_BOOT = 3'd0;
	localparam ST_TEST = 3'd1;
	localparam ST_CFG  = 3'd2;
	localparam ST_SYS  = 3'd3;
	localparam ST_USER = 3'd4;
	// cpu access kinds
	localparam K_READ  = 2'd0;
	localparam K_WRITE = 2'd1;
	localparam K_FETCH = 2'd2;

	////////////////////////////////////////////////////////////////////////////////
	// state

	reg  [2:0]  st_r;
	reg         ss_cfg_r;       // super-system flavour once out of boot
	reg         cl_opt_r;
	reg         test_avail_r;
	reg         contact_only_r;
	reg         irq_sys_r;
	reg  [IW-1:0] seg_idx_r;
	reg  [3:0]  seg_rt [0:SEG_N-1];
	reg  [15:0] seg_grp [0:SEG_N-1];
	reg  [23:0] seg_st [0:SEG_N-1];
	reg  [23:0] seg_en [0:SEG_N-1];
	reg  [23:0] seg_of [0:SEG_N-1];
	reg  [15:0] cfg_grp_r;
	reg  [15:0] user_grp_r;
	reg  [31:0] banked_r [0:2];
	reg  [1:0]  stk [0:STK_D-1];
	reg  [SPW-1:0] sp_r;
	reg         ack_r;
	reg  [23:0] fault_addr_r;
	integer     i;
	integer     j;              // lookup loop only, so no variable has two processes
	integer     k;

	wire super_flag  = (st_r == ST_BOOT) || (st_r == ST_TEST) || (st_r == ST_CFG);
	wire system_flag = (st_r == ST_SYS);
	wire user_mode   = (st_r == ST_USER);

	assign privilege_mode_word = {super_flag, system_flag};
	assign sfr_bank = user_mode ? 2'd0 : (system_flag ? 2'd1 : 2'd2);

	////////////////////////////////////////////////////////////////////////////////
	// segment lookup and translation

	reg          hit;
	reg          stop;
	reg [IW-1:0] hit_i;
	// first live entry wins; end marker stops, link marker is skipped
	always @* begin
		hit = 1'b0;
		stop = 1'b0;
		hit_i = {IW{1'b0}};
		for (j = 0; j < SEG_N; j = j + 1) begin
			if (!hit && !stop) begin
				if (seg_rt[j] == `MMAG_RT_END) begin
					stop = 1'b1;
				end else if (seg_rt[j] != `MMAG_RT_LINK &&
					cpu_vaddr >= seg_st[j] && cpu_vaddr <= seg_en[j]) begin
					hit = 1'b1;
					hit_i = j[IW-1:0];
				end
			end
		end
	end

	wire [3:0]  hit_rt = seg_rt[hit_i];
	wire right_ok = (cpu_kind == K_READ  && hit_rt[`MMAG_POS_RT_R]) ||
	                (cpu_kind == K_WRITE && hit_rt[`MMAG_POS_RT_W]) ||
	                (cpu_kind == K_FETCH && hit_rt[`MMAG_POS_RT_X]);
	// relocation only applies in user mode; privileged code sees identity
	wire [23:0] phys = user_mode ? cpu_vaddr + seg_of[hit_i] : cpu_vaddr;
	wire user_bad = user_mode && !(hit && right_ok);

	////////////////////////////////////////////////////////////////////////////////
	// physical range and partition check

	wire [24:0] ram_end = {1'b0, `MMAG_RAM_BASE} + {1'b0, RAM_SIZE};
	wire [24:0] ee_end  = {1'b0, `MMAG_EE_BASE}  + {1'b0, EE_SIZE};
	wire [24:0] rom_end = {1'b0, `MMAG_ROM_BASE} + {1'b0, ROM_SIZE};
	wire in_ram = phys >= `MMAG_RAM_BASE && {1'b0, phys} < ram_end;
	wire in_ee  = phys >= `MMAG_EE_BASE  && {1'b0, phys} < ee_end;
	wire in_rom = phys >= `MMAG_ROM_BASE && {1'b0, phys} < rom_end;
	reg  [23:0] reg_off;
	reg  [23:0] reg_half;
	// offset into the selected memory and its split point
	always @* begin
		reg_off = 24'h000000;
		reg_half = 24'h000000;
		if (in_ram) begin
			reg_off = phys - `MMAG_RAM_BASE;
			reg_half = RAM_SIZE >> 1;
		end else if (in_ee) begin
			reg_off = phys - `MMAG_EE_BASE;
			reg_half = EE_SIZE >> 1;
		end else if (in_rom) begin
			reg_off = phys - `MMAG_ROM_BASE;
			reg_half = ROM_SIZE >> 1;
		end
	end
	wire in_range = in_ram || in_ee || in_rom;
	// outside test mode the open half is chosen by the strap caught in boot, never by software
	wire part_ok  = (st_r == ST_TEST) || ((reg_off >= reg_half) == cl_opt_r);
	wire mem_fault = cpu_req && (!in_range || !part_ok || user_bad);

	////////////////////////////////////////////////////////////////////////////////
	// memory request and exception outputs

	wire system_entry_vector_bad = ev_system_entry_vector_call && !user_mode;
	wire interrupt_return_instruction_bad = ev_interrupt_return_instruction && user_mode && !(!irq_sys_r && irq_active);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_req_r <= 1'b0;
			mem_addr_r <= 24'h000000;
			exc_req_r <= 1'b0;
			exc_cause_r <= 3'h0;
			fault_addr_r <= 24'h000000;
		end else begin
			mem_req_r <= cpu_req && !mem_fault;
			mem_addr_r <= phys;
			exc_req_r <= mem_fault || system_entry_vector_bad || interrupt_return_instruction_bad;
			if (mem_fault) begin
				// a user violation wins: without a hit the relocated address means nothing
				exc_cause_r <= (!in_range && !user_bad) ? `MMAG_CAUSE_RANGE : `MMAG_CAUSE_USER;
				fault_addr_r <= phys;
			end else if (system_entry_vector_bad) begin
				exc_cause_r <= `MMAG_CAUSE_SYSTEM_ENTRY_VECTOR;
			end else if (interrupt_return_instruction_bad) begin
				exc_cause_r <= `MMAG_CAUSE_INTERRUPT_RETURN_INSTRUCTION;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// group rights report and register filter

	// user rights follow the segment that last supplied an instruction
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			user_grp_r <= 16'h0000;
			grp_rights_r <= 16'hffff;
		end else begin
			if (user_mode && cpu_req && cpu_kind == K_FETCH && hit)
				user_grp_r <= seg_grp[hit_i];
			if (user_mode)
				grp_rights_r <= user_grp_r;
			else if (st_r == ST_CFG)
				grp_rights_r <= cfg_grp_r;
			else
				grp_rights_r <= 16'hffff;
		end
	end

	// fixed table: cls0 open, cls1 privileged, cls2 super only, cls3 read only
	reg fix_ok;
	always @* begin
		case (sfr_cls)
			2'd0: fix_ok = 1'b1;
			2'd1: fix_ok = !user_mode;
			2'd2: fix_ok = super_flag;
			default: fix_ok = !sfr_wr;
		endcase
	end
	wire sfr_ok = sfr_is_grp ? grp_rights_r[sfr_grp] : fix_ok;
	assign sfr_wr_en = sfr_req && sfr_wr && sfr_ok;
	// a refused read never exposes the register, whatever it holds
	always @(posedge clk or posedge rst) begin
		if (rst)
			sfr_rdata_r <= `MMAG_FIXED_RDATA;
		else if (sfr_req && !sfr_wr)
			sfr_rdata_r <= sfr_ok ? sfr_periph_rdata : `MMAG_FIXED_RDATA;
	end

	////////////////////////////////////////////////////////////////////////////////
	// avalon handshake: one wait cycle per access

	wire av_req = avs_read || avs_write;
	wire av_wr  = avs_write && ack_r && (avs_byteenable == 4'hf);
	assign avs_waitrequest = av_req && !ack_r;
	always @(posedge clk or posedge rst) begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= av_req && !ack_r;
	end

	reg [31:0] rd_nxt;
	wire [1:0] bank_i = sfr_bank;
	// read mux; unmapped offsets read as zero
	always @* begin
		rd_nxt = 32'h00000000;
		if (avs_address == `MMAG_OFS_MODE)
			rd_nxt = {27'h0, st_r, super_flag, system_flag};
		else if (avs_address == `MMAG_OFS_CTRL)
			rd_nxt = {31'h0, irq_sys_r};
		else if (avs_address == `MMAG_OFS_SEG_IDX)
			rd_nxt = {{(32-IW){1'b0}}, seg_idx_r};
		else if (avs_address == `MMAG_OFS_SEG_RT)
			rd_nxt = {seg_grp[seg_idx_r], 12'h000, seg_rt[seg_idx_r]};
		else if (avs_address == `MMAG_OFS_SEG_ST)
			rd_nxt = {8'h00, seg_st[seg_idx_r]};
		else if (avs_address == `MMAG_OFS_SEG_EN)
			rd_nxt = {8'h00, seg_en[seg_idx_r]};
		else if (avs_address == `MMAG_OFS_SEG_OF)
			rd_nxt = {8'h00, seg_of[seg_idx_r]};
		else if (avs_address == `MMAG_OFS_GRP_LO)
			rd_nxt = {24'h0, cfg_grp_r[7:0]};
		else if (avs_address == `MMAG_OFS_GRP_HI)
			rd_nxt = {24'h0, cfg_grp_r[15:8]};
		else if (avs_address == `MMAG_OFS_BANKED)
			rd_nxt = banked_r[bank_i];
		else if (avs_address == `MMAG_OFS_STATUS)
			rd_nxt = {5'h0, exc_cause_r, fault_addr_r};
	end
	always @(posedge clk or posedge rst) begin
		if (rst)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !ack_r)
			avs_readdata <= rd_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	wire seg_we = av_wr && system_flag;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_sys_r <= `MMAG_RST_CTRL;
			seg_idx_r <= {IW{1'b0}};
			cfg_grp_r <= {`MMAG_RST_GRP, `MMAG_RST_GRP};
			for (i = 0; i < SEG_N; i = i + 1) begin
				seg_rt[i] <= `MMAG_RT_END;
				seg_grp[i] <= 16'h0000;
				seg_st[i] <= 24'h000000;
				seg_en[i] <= 24'h000000;
				seg_of[i] <= 24'h000000;
			end
			for (i = 0; i < 3; i = i + 1)
				banked_r[i] <= 32'h00000000;
		end else begin
			if (av_wr && system_flag && avs_address == `MMAG_OFS_CTRL)
				irq_sys_r <= avs_writedata[`MMAG_POS_IRQ_SYS];
			if (seg_we && avs_address == `MMAG_OFS_SEG_IDX)
				seg_idx_r <= avs_writedata[IW-1:0];
			if (seg_we && avs_address == `MMAG_OFS_SEG_RT) begin
				seg_rt[seg_idx_r] <= avs_writedata[3:0];
				seg_grp[seg_idx_r] <= avs_writedata[`MMAG_POS_SEG_GRP +: 16];
			end
			if (seg_we && avs_address == `MMAG_OFS_SEG_ST)
				seg_st[seg_idx_r] <= avs_writedata[23:0];
			if (seg_we && avs_address == `MMAG_OFS_SEG_EN)
				seg_en[seg_idx_r] <= avs_writedata[23:0];
			if (seg_we && avs_address == `MMAG_OFS_SEG_OF)
				seg_of[seg_idx_r] <= avs_writedata[23:0];
			// contactless mode cannot widen its own rights
			if (av_wr && st_r != ST_CFG && avs_address == `MMAG_OFS_GRP_LO)
				cfg_grp_r[7:0] <= avs_writedata[7:0];
			if (av_wr && st_r != ST_CFG && avs_address == `MMAG_OFS_GRP_HI)
				cfg_grp_r[15:8] <= avs_writedata[7:0];
			if (av_wr && avs_address == `MMAG_OFS_BANKED)
				banked_r[bank_i] <= avs_writedata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// privilege mode machine

	// restored or cleared bits map back to a state; boot is never reachable
	function [2:0] bits2st;
		input [1:0] b;
		input       cfg;
		begin
			if (b[`MMAG_POS_SSM])
				bits2st = cfg ? ST_CFG : ST_TEST;
			else if (b[`MMAG_POS_SM])
				bits2st = ST_SYS;
			else
				bits2st = ST_USER;
		end
	endfunction

	wire mode_wr   = av_wr && avs_address == `MMAG_OFS_MODE;
	wire entry_hit = ev_far_call && system_flag && call_target == `MMAG_ENTRY_VADDR;
	wire config_entry_vector_go   = ev_config_entry_vector_call && !contact_only_r;
	wire system_entry_vector_go   = ev_system_entry_vector_call && user_mode;
	wire irq_push  = ev_irq_entry;
	wire do_push   = ev_exception || irq_push || system_entry_vector_go || config_entry_vector_go;
	wire do_pop    = ev_interrupt_return_instruction && !interrupt_return_instruction_bad && sp_r != {SPW{1'b0}};
	wire [SPW-1:0] sp_dec = sp_r - {{(SPW-1){1'b0}}, 1'b1};
	wire [1:0] pop_bits = stk[sp_dec[$clog2(STK_D)-1:0]];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= ST_BOOT;
			ss_cfg_r <= 1'b1;
			cl_opt_r <= 1'b0;
			test_avail_r <= 1'b0;
			contact_only_r <= 1'b0;
			sp_r <= {SPW{1'b0}};
			for (k = 0; k < STK_D; k = k + 1)
				stk[k] <= 2'b00;
		end else begin
			// saved bits for the later interrupt return
			if (do_push && sp_r != STK_D[SPW-1:0]) begin
				stk[sp_r[$clog2(STK_D)-1:0]] <= privilege_mode_word;
				sp_r <= sp_r + {{(SPW-1){1'b0}}, 1'b1};
			end else if (do_pop) begin
				sp_r <= sp_dec;
			end
			case (st_r)
				ST_BOOT: begin
					// straps latched once here and held until the next reset
					cl_opt_r <= strap_contactless;
					test_avail_r <= strap_test_avail;
					contact_only_r <= strap_contact_only;
					if (ev_config_entry_vector_call && !strap_contact_only) begin
						st_r <= ST_CFG;
						ss_cfg_r <= 1'b1;
					end else if (strap_test_avail) begin
						st_r <= ST_TEST;
						ss_cfg_r <= 1'b0;
					end else begin
						st_r <= ST_SYS;
					end
				end
				default: begin
					if (ev_exception) begin
						st_r <= super_flag ? st_r : ST_SYS;
					end else if (irq_push) begin
						if (irq_sys_r && !super_flag)
							st_r <= ST_SYS;
					end else if (do_pop) begin
						st_r <= bits2st(pop_bits, ss_cfg_r);
					end else if (system_entry_vector_go) begin
						st_r <= ST_SYS;
					end else if (config_entry_vector_go) begin
						st_r <= ST_CFG;
						ss_cfg_r <= 1'b1;
					end else if (entry_hit) begin
						st_r <= ST_USER;
					end else if (mode_wr) begin
						st_r <= bits2st(privilege_mode_word & avs_writedata[1:0],
							ss_cfg_r);
					end
				end
			endcase
		end
	end

endmodule // mmag_guard

/* mmag_guard_assertions.sv */
`timescale 1ns/1ps
module mmag_guard_assertions (
	// clock and reset
	input logic        clk,
	input logic        rst,
	// bus
	input logic        avs_read,
	input logic        avs_write,
	input logic        avs_waitrequest,
	// cpu side
	input logic        cpu_req,
	input logic [23:0] cpu_vaddr,
	input logic        ev_exception,
	input logic        ev_irq_entry,
	input logic        ev_interrupt_return_instruction,
	input logic        ev_system_entry_vector_call,
	input logic        ev_config_entry_vector_call,
	input logic        ev_far_call,
	input logic [23:0] call_target,
	// guard outputs
	input logic        exc_req_r,
	input logic [2:0]  exc_cause_r,
	input logic [1:0]  privilege_mode_word,
	input logic [15:0] grp_rights_r,
	// register filter
	input logic        sfr_req,
	input logic        sfr_wr,
	input logic        sfr_is_grp,
	input logic [3:0]  sfr_grp,
	input logic [1:0]  sfr_cls,
	input logic        sfr_wr_en,
	input logic [1:0]  sfr_bank,
	input logic [7:0]  sfr_rdata_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// events that outrank a vector call
	wire hi_ev = ev_exception | ev_irq_entry | ev_interrupt_return_instruction;
	wire any_ev = hi_ev | ev_system_entry_vector_call | ev_config_entry_vector_call;
	wire [1:0] pmw = privilege_mode_word;
	// bus request waits exactly one cycle
	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest;
	endsequence
	a_bus_one_wait: assert property (s_req_wait |=> s_ack)
		else $error("bus answer not after one wait cycle");
	a_exc_sys_bit: assert property (ev_exception |=> pmw[0])
		else $error("exception entry left system bit clear");
	a_far_entry: assert property (ev_far_call && call_target == 24'h800000 && pmw == 2'b01
		&& !any_ev |=> pmw == 2'b00) else $error("entry call did not reach user mode");
	a_system_entry_vector_user: assert property (ev_system_entry_vector_call && !hi_ev && pmw == 2'b00 |=> pmw == 2'b01)
		else $error("system vector from user did not enter system mode");
	a_system_entry_vector_fault: assert property (ev_system_entry_vector_call && !hi_ev && pmw != 2'b00
		|=> exc_req_r && exc_cause_r == 3'h3 && $stable(pmw)) else $error("system vector fault");
	a_grp_full: assert property (pmw == 2'b01 [*2] |-> grp_rights_r == 16'hffff)
		else $error("system mode group rights not full");
	a_clear_only: assert property ($past(pmw) == 2'b00 && !$past(any_ev) |-> pmw == 2'b00)
		else $error("user mode left without an event");
	a_bank_sel: assert property (sfr_bank == (pmw == 2'b00 ? 2'd0 : (pmw[1] ? 2'd2 : 2'd1)))
		else $error("register copy does not follow mode");
	a_refused_rd: assert property (sfr_req && !sfr_wr && !sfr_is_grp && sfr_cls == 2'd2
		&& !pmw[1] |=> sfr_rdata_r == 8'h00) else $error("refused read not fixed value");
	a_grp_gate: assert property (sfr_req && sfr_wr && sfr_is_grp && !grp_rights_r[sfr_grp]
		|-> !sfr_wr_en) else $error("group write passed without right");
	a_range_fault: assert property (cpu_req && cpu_vaddr[23:20] == 4'h3 && pmw == 2'b01
		|=> exc_req_r && exc_cause_r == 3'h1) else $error("out of range access not faulted");
endmodule // mmag_guard_assertions

bind mmag_guard mmag_guard_assertions mmag_guard_assertions_inst (.clk, .rst, .avs_read,
	.avs_write, .avs_waitrequest, .cpu_req, .cpu_vaddr, .ev_exception, .ev_irq_entry,
	.ev_interrupt_return_instruction, .ev_system_entry_vector_call, .ev_config_entry_vector_call, .ev_far_call, .call_target, .exc_req_r,
	.exc_cause_r, .privilege_mode_word, .grp_rights_r, .sfr_req, .sfr_wr, .sfr_is_grp,
	.sfr_grp, .sfr_cls, .sfr_wr_en, .sfr_bank, .sfr_rdata_r);

/* mmag_cpu_model.sv */
`timescale 1ns/1ps
module mmag_cpu_model (
	// clock
	input  wire        clk,
	// requests and events toward the guard
	output reg         cpu_req,
	output reg  [1:0]  cpu_kind,
	output reg  [23:0] cpu_vaddr,
	output reg  [5:0]  ev,
	output reg  [23:0] call_target,
	output reg         irq_active
);
	////////////////////////////////////////
	// idle at time zero
	initial begin
		cpu_req = 1'b0;
		cpu_kind = 2'h0;
		cpu_vaddr = 24'h0;
		ev = 6'h00;
		call_target = 24'h0;
		irq_active = 1'b0;
	end
	// one request cycle; address inverted after so a stale value never looks valid
	task access(input [1:0] k, input [23:0] a);
		@(posedge clk);
		cpu_req <= 1'b1;
		cpu_kind <= k;
		cpu_vaddr <= a;
		@(posedge clk);
		cpu_req <= 1'b0;
		cpu_vaddr <= ~a;
	endtask
	// interrupt activity level, changed right after a rising edge
	task set_irq(input v);
		@(posedge clk);
		irq_active <= v;
	endtask
	// one-cycle pulse, bits: exception irq interrupt_return_instruction system_entry_vector config_entry_vector far
	task pulse(input [5:0] e, input [23:0] t);
		@(posedge clk);
		ev <= e;
		call_target <= t;
		@(posedge clk);
		ev <= 6'h00;
		call_target <= ~t;
	endtask
endmodule // mmag_cpu_model

/* test_mmu_mode_access_guard.sv */
`timescale 1ns/1ps
`include "mmag_map.vh"
module test_mmu_mode_access_guard;
	// bench signals
	reg         clk, rst, avs_read, avs_write, strap_test_avail;
	reg         strap_contactless, strap_contact_only;
	reg  [7:0]  avs_address, sfr_periph_rdata;
	reg  [31:0] avs_writedata, rd, nt;
	reg         sfr_req, sfr_wr, sfr_is_grp, ws;
	reg  [3:0]  sfr_grp;
	reg  [1:0]  sfr_cls;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest, cpu_req, irq_active, mem_req_r, exc_req_r, sfr_wr_en;
	wire [1:0]  cpu_kind, privilege_mode_word, sfr_bank;
	wire [23:0] cpu_vaddr, call_target, mem_addr_r;
	wire [5:0]  ev;
	wire [2:0]  exc_cause_r;
	wire [15:0] grp_rights_r;
	wire [7:0]  sfr_rdata_r;
	reg  [23:0] a;
	reg  [31:0] q[$];
	integer     err_total, checked, i;
	////////////////////////////////////////
	mmag_guard mmag_guard_inst (.clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.strap_contactless, .strap_test_avail, .strap_contact_only,
		.cpu_req, .cpu_kind, .cpu_vaddr, .ev_exception(ev[5]), .ev_irq_entry(ev[4]),
		.ev_interrupt_return_instruction(ev[3]), .ev_system_entry_vector_call(ev[2]), .ev_config_entry_vector_call(ev[1]), .ev_far_call(ev[0]),
		.call_target, .irq_active, .mem_req_r, .mem_addr_r, .exc_req_r, .exc_cause_r,
		.privilege_mode_word, .grp_rights_r, .sfr_req, .sfr_wr, .sfr_is_grp, .sfr_grp,
		.sfr_cls, .sfr_periph_rdata, .sfr_wr_en, .sfr_bank, .sfr_rdata_r);
	mmag_cpu_model mmag_cpu_model_inst (.clk, .cpu_req, .cpu_kind, .cpu_vaddr, .ev,
		.call_target, .irq_active);
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task end_of_test;
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		checked = checked + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	function [27:0] fl(input [2:0] c);
		fl = {1'b1, c, 24'h0};
	endfunction
	// bus cycle held until waitrequest is sampled low
	task bus(input w, input [7:0] ad, input [31:0] d);
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= ad;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// cpu access with its expected result noted first
	task acc(input [1:0] k, input [23:0] va, input [27:0] n);
		q.push_back(n);
		mmag_cpu_model_inst.access(k, va);
	endtask
	task ev_md(input [5:0] e, input [23:0] t, input [1:0] m);
		mmag_cpu_model_inst.pulse(e, t);
		#1;
		chk(privilege_mode_word, m);
	endtask
	// register filter request; write strobe kept, read data settled after
	task sfr(input w, input g, input [3:0] gi, input [1:0] c);
		@(posedge clk);
		sfr_req <= 1'b1;
		sfr_wr <= w;
		sfr_is_grp <= g;
		sfr_grp <= gi;
		sfr_cls <= c;
		#1;
		ws = sfr_wr_en;
		@(posedge clk);
		sfr_req <= 1'b0;
		#1;
	endtask
	task do_reset(input t, input c, input o);
		rst <= 1'b1;
		strap_test_avail <= t;
		strap_contactless <= c;
		strap_contact_only <= o;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// result monitor: oldest note against each memory answer
	always @(posedge clk)
		if (!rst && (mem_req_r === 1'b1 || exc_req_r === 1'b1)) begin
			nt = (q.size() > 0) ? q.pop_front() : 32'hffffffff;
			chk(exc_req_r ? {1'b1, exc_cause_r, 24'h0} : {4'h0, mem_addr_r}, nt);
		end
	// watchdog, far beyond the roughly 140 cycles of the run
	initial begin
		#40000;
		err_total = err_total + 1;
		end_of_test;
	end
	initial begin
		err_total = 0;
		checked = 0;
		{rst, avs_read, avs_write, sfr_req, sfr_wr, sfr_is_grp} = 6'h20;
		{avs_address, avs_writedata, sfr_grp, sfr_cls, sfr_periph_rdata} = 0;
		i = $urandom(32'he4a91736);
		do_reset(1'b0, 1'b0, 1'b0);
		chk(privilege_mode_word, 2'b01);
		chk(grp_rights_r, 16'hffff);
		chk(sfr_bank, 2'd1);
		bus(1'b0, `MMAG_OFS_CTRL, 0);
		chk(rd[0], `MMAG_RST_CTRL);
		bus(1'b0, 8'hfc, 0);
		chk(rd, 0);
		for (i = 0; i < 4; i = i + 1) begin
			a = $urandom % 24'h1000;
			acc(i[1:0] % 3, a, {4'h0, a});
		end
		acc(2'd1, 24'h001800, fl(`MMAG_CAUSE_USER));
		acc(2'd0, 24'h300000, fl(`MMAG_CAUSE_RANGE));
		sfr_periph_rdata <= $urandom;
		sfr(1'b0, 1'b0, 4'd0, 2'd2);
		chk(sfr_rdata_r, `MMAG_FIXED_RDATA);
		sfr(1'b0, 1'b0, 4'd0, 2'd0);
		chk(sfr_rdata_r, sfr_periph_rdata);
		sfr(1'b1, 1'b0, 4'd0, 2'd2);
		chk(ws, 0);
		bus(1'b1, `MMAG_OFS_SEG_IDX, 0);
		bus(1'b1, `MMAG_OFS_SEG_RT, 32'h00050007);
		bus(1'b1, `MMAG_OFS_SEG_ST, 32'h800000);
		bus(1'b1, `MMAG_OFS_SEG_EN, 32'h800fff);
		bus(1'b1, `MMAG_OFS_SEG_OF, 32'ha00000);
		bus(1'b0, `MMAG_OFS_SEG_RT, 0);
		chk(rd, 32'h00050007);
		// entry 1 is a continuation covering 0x900000: it must be skipped
		bus(1'b1, `MMAG_OFS_SEG_IDX, 1);
		bus(1'b1, `MMAG_OFS_SEG_RT, `MMAG_RT_LINK);
		bus(1'b1, `MMAG_OFS_SEG_ST, 32'h900000);
		bus(1'b1, `MMAG_OFS_SEG_EN, 32'h900fff);
		// contactless rights come from the group registers, frozen in that mode
		bus(1'b1, `MMAG_OFS_GRP_LO, 32'h12);
		ev_md(6'h02, 0, 2'b10);
		bus(1'b1, `MMAG_OFS_GRP_LO, 32'h00);
		bus(1'b0, `MMAG_OFS_GRP_LO, 0);
		chk(rd, 32'h12);
		chk(grp_rights_r, 16'hff12);
		chk(sfr_bank, 2'd2);
		ev_md(6'h08, 0, 2'b01);
		q.push_back(fl(`MMAG_CAUSE_SYSTEM_ENTRY_VECTOR));
		ev_md(6'h04, 0, 2'b01);
		ev_md(6'h01, `MMAG_ENTRY_VADDR, 2'b00);
		chk(sfr_bank, 2'd0);
		acc(2'd2, 24'h800010, {4'h0, 24'h200010});
		acc(2'd0, 24'h900000, fl(`MMAG_CAUSE_USER));
		repeat (2) @(posedge clk);
		#1;
		chk(grp_rights_r, 16'h0005);
		sfr(1'b1, 1'b1, 4'd1, 2'd0);
		chk(ws, 0);
		sfr(1'b1, 1'b1, 4'd2, 2'd0);
		chk(ws, 1);
		bus(1'b1, `MMAG_OFS_MODE, 32'h3);
		#1;
		chk(privilege_mode_word, 2'b00);
		ev_md(6'h04, 0, 2'b01);
		ev_md(6'h08, 0, 2'b00);
		ev_md(6'h20, 0, 2'b01);
		bus(1'b1, `MMAG_OFS_MODE, 32'h0);
		#1;
		chk(privilege_mode_word, 2'b00);
		q.push_back(fl(`MMAG_CAUSE_INTERRUPT_RETURN_INSTRUCTION));
		ev_md(6'h08, 0, 2'b00);
		ev_md(6'h10, 0, 2'b01);
		bus(1'b1, `MMAG_OFS_CTRL, 0);
		ev_md(6'h08, 0, 2'b00);
		ev_md(6'h10, 0, 2'b00);
		mmag_cpu_model_inst.set_irq(1'b1);
		ev_md(6'h08, 0, 2'b00);
		do_reset(1'b1, 1'b0, 1'b0);
		chk(privilege_mode_word, 2'b10);
		chk(sfr_bank, 2'd2);
		acc(2'd0, 24'h001800, {4'h0, 24'h001800});
		// let the last answer appear before reset clears it
		repeat (2) @(posedge clk);
		do_reset(1'b0, 1'b1, 1'b1);
		chk(privilege_mode_word, 2'b01);
		acc(2'd0, 24'h001800, {4'h0, 24'h001800});
		acc(2'd0, 24'h000800, fl(`MMAG_CAUSE_USER));
		ev_md(6'h02, 0, 2'b01);
		repeat (3) @(posedge clk);
		chk(q.size(), 0);
		end_of_test;
	end
endmodule // test_mmu_mode_access_guard
